// File: verilog/hub_desc_pkg.sv
// Constants and carriers for the hub descriptor table.
// Assumes one 100 MHz core clock; config values are stable while a request is served.
package hub_desc_pkg;

    // ------------------------------------------------------------------
    // Descriptor types, also used as request kind codes
    // ------------------------------------------------------------------
    localparam logic [7:0] DT_DEVICE    = 8'h01;
    localparam logic [7:0] DT_INTERFACE = 8'h04;
    localparam logic [7:0] DT_ENDPOINT  = 8'h05;

    // ------------------------------------------------------------------
    // Descriptor lengths
    // ------------------------------------------------------------------
    localparam logic [7:0] LEN_DEVICE    = 8'h12;
    localparam logic [7:0] LEN_INTERFACE = 8'h09;
    localparam logic [7:0] LEN_ENDPOINT  = 8'h07;

    // ------------------------------------------------------------------
    // Field values
    // ------------------------------------------------------------------
    localparam logic [15:0] BCD_USB       = 16'h0200;
    localparam logic [7:0]  CLASS_HUB     = 8'h09;
    localparam logic [7:0]  SUBCLASS_HUB  = 8'h00;
    localparam logic [7:0]  PROTO_MULTI   = 8'h02;
    localparam logic [7:0]  PROTO_INTF    = 8'h00;
    localparam logic [7:0]  MPS_EP0       = 8'h40;
    localparam logic [7:0]  NUM_CONFIGS   = 8'h01;
    localparam logic [7:0]  INTF_NUMBER   = 8'h00;
    localparam logic [7:0]  ALT_SETTING   = 8'h00;
    localparam logic [7:0]  NUM_ENDPOINTS = 8'h01;
    localparam logic [7:0]  STR_NONE      = 8'h00;
    localparam logic [7:0]  STR_MFR       = 8'h01;
    localparam logic [7:0]  STR_PRODUCT   = 8'h02;
    localparam logic [7:0]  STR_SERIAL    = 8'h03;
    localparam logic [7:0]  EP_ADDR_IN1   = 8'h81;
    localparam logic [7:0]  EP_ATTR_INTR  = 8'h03;
    localparam logic [15:0] EP_MAX_PKT    = 16'h0001;
    localparam logic [7:0]  EP_INTERVAL   = 8'h0C;

    // ------------------------------------------------------------------
    // Byte offsets of the fields that are not fixed constants, and the start offset
    // ------------------------------------------------------------------
    localparam logic [4:0] OFS_VENDOR  = 5'h08;
    localparam logic [4:0] OFS_PRODUCT = 5'h0A;
    localparam logic [4:0] OFS_DEVICE  = 5'h0C;
    localparam logic [4:0] OFS_STR_MFR = 5'h0E;
    localparam logic [4:0] OFS_STR_PRD = 5'h0F;
    localparam logic [4:0] OFS_STR_SER = 5'h10;
    localparam logic [4:0] OFS_RESET   = 5'h00;

    typedef enum {ST_IDLE, ST_SEND} desc_state_t;

    typedef struct packed {
        logic [15:0] vendor_id;
        logic [15:0] product_id;
        logic [15:0] device_id;
        logic        string_en;
        logic        multi_tt;
    } desc_cfg_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  kind;
        logic [15:0] max_len;
    } desc_req_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  data;
        logic [4:0]  offset;
        logic        last;
        logic        stall;
    } desc_resp_t;

endpackage : hub_desc_pkg

// File: verilog/hub_descriptor_table_logic.sv
// Descriptor byte source for the hub's standard get-descriptor requests.
// Assumes the request decoder and config loader run on sys_clk; no pin inputs here.
// Notes on behaviour
// - Single-TT interface descriptor: length 09h, type 04h
// - Interface number and alternate setting both 00h
// - One endpoint, hub class 09h, subclass 00h
// - Interface protocol 00h, no interface string
// - Endpoint descriptor: length 07h, type 05h
// - Endpoint address 81h, endpoint one IN
// - Endpoint attributes 03h, interrupt endpoint
// - Max packet 0001h, little endian at offset 4
// - Polling interval byte 0Ch
// - Device descriptor 12h long, type 01h, one config
// - Release 0200h and control packet size 40h
// - Device class 09h, subclass 00h
// - Multi-TT device protocol byte 02h
// - Vendor, product, device ids from configuration
// - String indexes 00 or 01/02/03 by enable
module hub_descriptor_table_logic
    import hub_desc_pkg::*;
(
    input  wire logic       sys_clk,  // Core clock, 100 MHz
    input  wire logic       rst_n,    // Synchronous reset, active low
    input  wire logic       ce,       // Clock enable, freezes all state when low
    input  wire desc_cfg_t  cfg,      // Loaded customer configuration
    input  wire desc_req_t  req,      // Get-descriptor request
    input  wire logic       tx_ready, // Consumer takes the presented byte
    output      desc_resp_t resp,     // Byte stream and refusal pulse
    output      logic       busy      // A descriptor is being streamed
);

    typedef struct packed {
        desc_state_t state;
        logic        busy;
        logic [7:0]  kind;
        logic [4:0]  end_idx;
        desc_resp_t  resp;
    } core_t;

    core_t s;
    core_t next_s;

    // ------------------------------------------------------------------
    // Descriptor contents
    // ------------------------------------------------------------------
    function automatic logic [7:0] desc_byte(input logic [7:0] kind, input logic [4:0] idx,
                                             input desc_cfg_t c);
        logic [7:0] b;
        b = 8'h00;
        if (kind == DT_DEVICE) begin
            case (idx)
                5'h00:   b = LEN_DEVICE;
                5'h01:   b = DT_DEVICE;
                5'h02:   b = BCD_USB[7:0];
                5'h03:   b = BCD_USB[15:8];
                5'h04:   b = CLASS_HUB;
                5'h05:   b = SUBCLASS_HUB;
                5'h06:   b = PROTO_MULTI;
                5'h07:   b = MPS_EP0;
                5'h08:   b = c.vendor_id[7:0];
                5'h09:   b = c.vendor_id[15:8];
                5'h0A:   b = c.product_id[7:0];
                5'h0B:   b = c.product_id[15:8];
                5'h0C:   b = c.device_id[7:0];
                5'h0D:   b = c.device_id[15:8];
                5'h0E:   b = c.string_en ? STR_MFR : STR_NONE;
                5'h0F:   b = c.string_en ? STR_PRODUCT : STR_NONE;
                5'h10:   b = c.string_en ? STR_SERIAL : STR_NONE;
                5'h11:   b = NUM_CONFIGS;
                default: b = 8'h00;
            endcase
        end else if (kind == DT_INTERFACE) begin
            case (idx)
                5'h00:   b = LEN_INTERFACE;
                5'h01:   b = DT_INTERFACE;
                5'h02:   b = INTF_NUMBER;
                5'h03:   b = ALT_SETTING;
                5'h04:   b = NUM_ENDPOINTS;
                5'h05:   b = CLASS_HUB;
                5'h06:   b = SUBCLASS_HUB;
                5'h07:   b = PROTO_INTF;
                5'h08:   b = STR_NONE;
                default: b = 8'h00;
            endcase
        end else begin
            case (idx)
                5'h00:   b = LEN_ENDPOINT;
                5'h01:   b = DT_ENDPOINT;
                5'h02:   b = EP_ADDR_IN1;
                5'h03:   b = EP_ATTR_INTR;
                5'h04:   b = EP_MAX_PKT[7:0];
                5'h05:   b = EP_MAX_PKT[15:8];
                5'h06:   b = EP_INTERVAL;
                default: b = 8'h00;
            endcase
        end
        return b;
    endfunction : desc_byte

    // ------------------------------------------------------------------
    // Request acceptance and streaming
    // ------------------------------------------------------------------
    logic        supported;
    logic [7:0]  full_len;
    logic [15:0] eff_len;

    always_comb begin
        // Only the set matching the translator mode is served
        supported = cfg.multi_tt ? (req.kind == DT_DEVICE)
                                 : (req.kind == DT_INTERFACE || req.kind == DT_ENDPOINT);
        case (req.kind)
            DT_DEVICE:    full_len = LEN_DEVICE;
            DT_INTERFACE: full_len = LEN_INTERFACE;
            default:      full_len = LEN_ENDPOINT;
        endcase
        // Host may ask for fewer bytes than the descriptor holds
        eff_len = (req.max_len < {8'h00, full_len}) ? req.max_len : {8'h00, full_len};
    end

    always_comb begin
        next_s = s;
        next_s.resp.stall = 1'b0;
        case (s.state)
            ST_IDLE: begin
                next_s.resp.valid = 1'b0;
                if (req.valid) begin
                    if (!supported || req.max_len == 16'h0000) begin
                        next_s.resp.stall = 1'b1;
                    end else begin
                        next_s.state       = ST_SEND;
                        next_s.busy        = 1'b1;
                        next_s.kind        = req.kind;
                        next_s.end_idx     = 5'(eff_len - 16'h0001);
                        next_s.resp.valid  = 1'b1;
                        next_s.resp.offset = OFS_RESET;
                        next_s.resp.data   = desc_byte(req.kind, OFS_RESET, cfg);
                        next_s.resp.last   = (eff_len == 16'h0001);
                    end
                end
            end
            ST_SEND: begin
                if (tx_ready) begin
                    if (s.resp.last) begin
                        next_s.state      = ST_IDLE;
                        next_s.busy       = 1'b0;
                        next_s.resp.valid = 1'b0;
                        next_s.resp.last  = 1'b0;
                    end else begin
                        // Offsets walk upward one per accepted byte
                        next_s.resp.offset = s.resp.offset + 5'h01;
                        next_s.resp.data   = desc_byte(s.kind, s.resp.offset + 5'h01, cfg);
                        next_s.resp.last   = (s.resp.offset + 5'h01 == s.end_idx);
                    end
                end
            end
            default: begin
                next_s.state      = ST_IDLE;
                next_s.busy       = 1'b0;
                next_s.resp.valid = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s <= '{state: ST_IDLE, busy: 1'b0, kind: 8'h00, end_idx: 5'h00,
                   resp: '{valid: 1'b0, data: 8'h00, offset: OFS_RESET, last: 1'b0, stall: 1'b0}};
        end else if (ce) begin
            s <= next_s;
        end
    end

    // Busy kept as its own flop so the port needs no decode
    assign resp = s.resp;
    assign busy = s.busy;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_intf_header: assert property (@(posedge sys_clk) disable iff (!rst_n)
        resp.valid && s.kind == DT_INTERFACE && resp.offset <= 5'h01
        |-> resp.data == (resp.offset == 5'h00 ? LEN_INTERFACE : DT_INTERFACE))
        else $error("interface header byte wrong");

    chk_intf_number: assert property (@(posedge sys_clk) disable iff (!rst_n)
        resp.valid && s.kind == DT_INTERFACE && (resp.offset == 5'h02 || resp.offset == 5'h03)
        |-> resp.data == INTF_NUMBER)
        else $error("interface number or alternate setting wrong");

    chk_intf_class: assert property (@(posedge sys_clk) disable iff (!rst_n)
        resp.valid && s.kind == DT_INTERFACE && resp.offset == 5'h04 && tx_ready && ce
        ##1 resp.valid |-> resp.data == CLASS_HUB && $past(resp.data) == NUM_ENDPOINTS)
        else $error("endpoint count or hub class wrong");

    chk_intf_proto: assert property (@(posedge sys_clk) disable iff (!rst_n)
        resp.valid && s.kind == DT_INTERFACE && resp.offset >= 5'h07 |-> resp.data == 8'h00)
        else $error("interface protocol or string index not zero");

    chk_ep_header: assert property (@(posedge sys_clk) disable iff (!rst_n)
        resp.valid && s.kind == DT_ENDPOINT && resp.offset <= 5'h01
        |-> resp.data == (resp.offset == 5'h00 ? LEN_ENDPOINT : DT_ENDPOINT))
        else $error("endpoint length or type wrong");

    chk_ep_address: assert property (@(posedge sys_clk) disable iff (!rst_n)
        resp.valid && s.kind == DT_ENDPOINT && resp.offset == 5'h02 |-> resp.data == EP_ADDR_IN1)
        else $error("endpoint address wrong");

    chk_ep_attr: assert property (@(posedge sys_clk) disable iff (!rst_n)
        resp.valid && s.kind == DT_ENDPOINT && resp.offset == 5'h03 |-> resp.data == EP_ATTR_INTR)
        else $error("endpoint attributes wrong");

    chk_ep_maxpkt: assert property (@(posedge sys_clk) disable iff (!rst_n)
        resp.valid && s.kind == DT_ENDPOINT && (resp.offset == 5'h04 || resp.offset == 5'h05)
        |-> resp.data == (resp.offset == 5'h04 ? EP_MAX_PKT[7:0] : EP_MAX_PKT[15:8]))
        else $error("endpoint max packet wrong");

    chk_ep_interval: assert property (@(posedge sys_clk) disable iff (!rst_n)
        resp.valid && s.kind == DT_ENDPOINT && resp.offset == 5'h06 |-> resp.data == EP_INTERVAL)
        else $error("endpoint interval wrong");

    chk_dev_length: assert property (@(posedge sys_clk) disable iff (!rst_n)
        resp.valid && s.kind == DT_DEVICE && (resp.offset == 5'h00 || resp.offset == 5'h11)
        |-> resp.data == (resp.offset == 5'h00 ? LEN_DEVICE : NUM_CONFIGS))
        else $error("device length or configuration count wrong");

    chk_dev_mps: assert property (@(posedge sys_clk) disable iff (!rst_n)
        resp.valid && s.kind == DT_DEVICE && resp.offset == 5'h07 |-> resp.data == MPS_EP0)
        else $error("control packet size wrong");

    chk_dev_class: assert property (@(posedge sys_clk) disable iff (!rst_n)
        resp.valid && s.kind == DT_DEVICE && resp.offset == 5'h04 |-> resp.data == CLASS_HUB)
        else $error("device class wrong");

    chk_dev_proto: assert property (@(posedge sys_clk) disable iff (!rst_n)
        resp.valid && s.kind == DT_DEVICE && resp.offset == 5'h06 |-> resp.data == PROTO_MULTI)
        else $error("device protocol wrong");

    chk_dev_vendor: assert property (@(posedge sys_clk) disable iff (!rst_n)
        resp.valid && s.kind == DT_DEVICE && resp.offset == OFS_VENDOR && $stable(cfg)
        |-> resp.data == cfg.vendor_id[7:0])
        else $error("vendor id low byte wrong");

    chk_dev_strings: assert property (@(posedge sys_clk) disable iff (!rst_n)
        resp.valid && s.kind == DT_DEVICE && resp.offset == OFS_STR_SER && $stable(cfg)
        |-> resp.data == (cfg.string_en ? STR_SERIAL : STR_NONE))
        else $error("serial string index wrong");

    chk_mode_select: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ce && !busy && req.valid && !supported |=> resp.stall && !resp.valid)
        else $error("request outside the mode's set not refused");

    chk_offset_order: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ce && resp.valid && tx_ready && !resp.last |=> resp.valid && resp.offset == $past(resp.offset) + 5'h01)
        else $error("offset did not advance by one");

endmodule : hub_descriptor_table_logic

// File: tb/host_model.sv
// Host-side consumer of the descriptor byte stream.
// Assumes the block's sys_clk domain; records each accepted byte for the bench to judge.
module host_model
    import hub_desc_pkg::*;
(
    input  wire logic       sys_clk,  // Core clock
    input  wire logic       rst_n,    // Synchronous reset, active low
    input  wire logic       ce,       // Clock enable of the block
    input  wire logic       slow,     // Accept every other cycle when high
    input  wire desc_resp_t resp,     // Byte stream from the block
    output      logic       tx_ready  // Byte taken at this edge
);
    timeunit 1ns;
    timeprecision 100ps;

    logic       phase;
    logic [7:0] got[$];
    logic [4:0] offs[$];
    logic       lasts[$];

    // Slow mode stretches every byte, so hold logic is exercised
    assign tx_ready = !slow || phase;

    always @(posedge sys_clk) begin
        phase <= rst_n ? !phase : 1'b0;
        // Bytes gathered in arrival order
        if (rst_n && ce && tx_ready && resp.valid) begin
            got.push_back(resp.data);
            offs.push_back(resp.offset);
            lasts.push_back(resp.last);
        end
    end
endmodule : host_model

// File: tb/tb.sv
// Self-checking bench for the hub descriptor table.
// Assumes hub_desc_pkg and host_model are compiled first.
module tb
    import hub_desc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic       sys_clk, rst_n, ce, slow, tx_ready, busy;
    desc_cfg_t  cfg;
    desc_req_t  req;
    desc_resp_t resp;
    logic [7:0] exp_q[$];
    int         fail_count, cmp_count;

    hub_descriptor_table_logic dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .cfg(cfg), .req(req),
                                      .tx_ready(tx_ready), .resp(resp), .busy(busy));
    host_model host_u (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .slow(slow), .resp(resp), .tx_ready(tx_ready));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = !sys_clk;
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask : check8

    task automatic check1(input string name, input logic exp, input logic got);
        check8(name, {7'h00, exp}, {7'h00, got});
    endtask : check1

    // One-cycle request, taken at the next edge while idle
    task automatic send(input logic [7:0] kind, input logic [15:0] max_len);
        @(posedge sys_clk);
        #1 req = '{1'b1, kind, max_len};
        @(posedge sys_clk);
        #1 req.valid = 1'b0;
    endtask : send

    // Bounded wait, then byte, offset and last flag per position
    task automatic expect_bytes();
        int i;
        for (i = 0; i < 200 && !(host_u.got.size() >= exp_q.size() && busy === 1'b0); i++) begin
            @(posedge sys_clk);
            #1;
        end
        check8("count", 8'(exp_q.size()), 8'(host_u.got.size()));
        for (i = 0; i < exp_q.size() && i < host_u.got.size(); i++) begin
            check8("data", exp_q[i], host_u.got[i]);
            check8("offset", 8'(i), {3'h0, host_u.offs[i]});
            check1("last", i == exp_q.size() - 1, host_u.lasts[i]);
        end
        host_u.got.delete();
        host_u.offs.delete();
        host_u.lasts.delete();
    endtask : expect_bytes

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_interface();
        cfg.multi_tt = 1'b0;
        slow = 1'b1;
        send(8'h04, 16'h0040);
        check1("busy", 1'b1, busy);
        exp_q = '{8'h09, 8'h04, 8'h00, 8'h00, 8'h01, 8'h09, 8'h00, 8'h00, 8'h00};
        expect_bytes();
    endtask : t_interface

    // Clock enable dropped mid-stream must not lose or repeat a byte
    task automatic t_endpoint();
        slow = 1'b0;
        send(8'h05, 16'h0040);
        @(posedge sys_clk);
        #1 ce = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 ce = 1'b1;
        exp_q = '{8'h07, 8'h05, 8'h81, 8'h03, 8'h01, 8'h00, 8'h0C};
        expect_bytes();
    endtask : t_endpoint

    task automatic t_device(input logic s, input logic [15:0] v, input logic [15:0] p, input logic [15:0] d);
        logic [7:0] sm;
        sm = s ? 8'h01 : 8'h00;
        cfg = '{v, p, d, s, 1'b1};
        send(8'h01, 16'hFFFF);
        exp_q = '{8'h12, 8'h01, 8'h00, 8'h02, 8'h09, 8'h00, 8'h02, 8'h40, v[7:0], v[15:8], p[7:0], p[15:8],
                  d[7:0], d[15:8], sm, 8'(sm * 2), 8'(sm * 3), 8'h01};
        expect_bytes();
    endtask : t_device

    // Host asks for less than the whole descriptor; a request while busy is ignored
    task automatic t_truncate();
        cfg.multi_tt = 1'b1;
        send(8'h01, 16'h0003);
        send(8'h01, 16'h0001);
        exp_q = '{8'h12, 8'h01, 8'h00};
        expect_bytes();
        send(8'h01, 16'h0001);
        exp_q = '{8'h12};
        expect_bytes();
    endtask : t_truncate

    // Kinds outside the mode's set, and a zero length, are refused
    task automatic t_refuse();
        logic [24:0] tbl[4] = '{{1'b0, 8'h01, 16'h0040}, {1'b1, 8'h04, 16'h0040},
                                {1'b1, 8'h05, 16'h0040}, {1'b0, 8'h04, 16'h0000}};
        for (int i = 0; i < 4; i++) begin
            cfg.multi_tt = tbl[i][24];
            send(tbl[i][23:16], tbl[i][15:0]);
            check1("stall", 1'b1, resp.stall);
            check1("valid", 1'b0, resp.valid);
            @(posedge sys_clk);
            #1 check1("stall_end", 1'b0, resp.stall);
            check1("busy_idle", 1'b0, busy);
        end
    endtask : t_refuse

    // ------------------------------------------------------------------
    // Verdict and main sequence
    // ------------------------------------------------------------------
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        #20000;
        fail_count++;
        give_verdict();
    end

    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        slow = 1'b0;
        cfg = '{16'h1234, 16'h5678, 16'h9ABC, 1'b0, 1'b0};
        req = '{1'b0, 8'h00, 16'h0000};
        repeat (6) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        check1("busy_rst", 1'b0, busy);
        t_interface();
        t_endpoint();
        t_device(1'b0, 16'hA5C3, 16'h0F1E, 16'h7001);
        t_device(1'b1, 16'h3C5A, 16'hE1F0, 16'h0107);
        t_truncate();
        t_refuse();
        give_verdict();
    end
endmodule : tb
